// ===== logic/rtdc_top.sv
`timescale 1ns/100ps
module rtdc_top (
    // Clock, reset, enable
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // Command port from the management protocol engine
    input wire logic cmd_wr_i,
    input wire logic cmd_rd_i,
    input wire logic [7:0] cmd_code_i,
    input wire logic [7:0] page_i,
    input wire logic [15:0] wdata_i,
    output logic [15:0] rdata_o,
    output logic cmd_ack_o,
    output logic cmd_nak_o,
    // Rail one current sense
    input wire logic [1:0] phases_i,
    input wire logic sense_vld_i,
    input wire logic [rtdc_pkg::RTDC_SENSE_W-1:0] sense_i,
    input wire logic fault_clr_i,
    // Detector results
    output logic [rtdc_pkg::RTDC_FLD_W-1:0] limit_active_o,
    output logic trip_o,
    output logic fault_o
);
    import rtdc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [RTDC_FLD_W-1:0] fld_q [0:3];
    logic [3:0] fld_we;
    logic [RTDC_FLD_W-1:0] fld_d [0:3];
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;
    logic ack_r;
    logic nak_r;
    logic [RTDC_FLD_W-1:0] limit_r;
    logic trip_r;
    logic fault_r;
    logic [2:0] cnt_r;
    logic [2:0] cnt_nxt;
    rtdc_state_e state_r;
    rtdc_state_e state_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // Command decode
    wire page_ok = (page_i == RTDC_PAGE_RAIL1);
    wire hit_12 = page_ok && (cmd_code_i == RTDC_CMD_LIMIT_12);
    wire hit_34 = page_ok && (cmd_code_i == RTDC_CMD_LIMIT_34);
    wire hit = hit_12 || hit_34;
    wire req = cmd_wr_i || cmd_rd_i;
    wire wr_12 = ce_i && cmd_wr_i && hit_12;
    wire wr_34 = ce_i && cmd_wr_i && hit_34;

    // Write enables and data per field; top four bits are dropped here
    // reserved bits discarded
    assign fld_we = {wr_34, wr_34, wr_12, wr_12};
    assign fld_d[0] = wdata_i[RTDC_LO_MSB:RTDC_LO_LSB];
    assign fld_d[1] = wdata_i[RTDC_HI_MSB:RTDC_HI_LSB];
    assign fld_d[2] = wdata_i[RTDC_LO_MSB:RTDC_LO_LSB];
    assign fld_d[3] = wdata_i[RTDC_HI_MSB:RTDC_HI_LSB];

    ////////////////////////////////////////////////////////////////////////////
    // Limit fields
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_fld
            rtdc_field u_field (
                .mclk_i(mclk_i),
                .rst_n_i(rst_n_i),
                .ce_i(ce_i),
                .we_i(fld_we[gi]),
                .d_i(fld_d[gi]),
                .q_o(fld_q[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Read data and answers
    // reserved bits read zero
    wire [15:0] word_12 = {RTDC_RSV_VAL, fld_q[1], fld_q[0]};
    wire [15:0] word_34 = {RTDC_RSV_VAL, fld_q[3], fld_q[2]};
    assign rdata_nxt = hit_12 ? word_12 : (hit_34 ? word_34 : 16'h0000);

    // Answer one cycle after each request taken while ce_i is high; read data holds until next read with ce_i high
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_r <= 16'h0000;
            ack_r <= 1'b0;
            nak_r <= 1'b0;
        end else if (ce_i) begin
            if (cmd_rd_i) begin
                rdata_r <= rdata_nxt;
            end
            ack_r <= req && hit;
            nak_r <= req && !hit;
        end
    end

    assign rdata_o = rdata_r;
    assign cmd_ack_o = ack_r;
    assign cmd_nak_o = nak_r;

    ////////////////////////////////////////////////////////////////////////////
    // Sustained overcurrent detector
    // pick limit by phases
    wire [RTDC_FLD_W-1:0] limit_sel = fld_q[phases_i];
    wire over = sense_vld_i && (sense_i > {1'b0, limit_sel});
    wire under = sense_vld_i && !over;
    wire last = (cnt_r == RTDC_TRIP_SAMPLES - RTDC_CNT_ONE);

    // Next state and run count
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        case (state_r)
            RTDC_ST_CLEAR: begin
                if (over) begin
                    state_nxt = RTDC_ST_OVER;
                    cnt_nxt = RTDC_CNT_ONE;
                end
            end
            RTDC_ST_OVER: begin
                if (under) begin
                    state_nxt = RTDC_ST_CLEAR;
                    cnt_nxt = 3'h0;
                end else if (over && last) begin
                    state_nxt = RTDC_ST_TRIP;
                    cnt_nxt = 3'h0;
                end else if (over) begin
                    cnt_nxt = cnt_r + RTDC_CNT_ONE;
                end
            end
            RTDC_ST_TRIP: begin
                if (under) begin
                    state_nxt = RTDC_ST_CLEAR;
                end
            end
            default: begin
                state_nxt = RTDC_ST_CLEAR;
                cnt_nxt = 3'h0;
            end
        endcase
    end

    wire trip_nxt = (state_r == RTDC_ST_OVER) && over && last;

    // State, trip pulse and sticky fault; a trip beats a clear
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r <= RTDC_ST_CLEAR;
            cnt_r <= 3'h0;
            trip_r <= 1'b0;
            fault_r <= 1'b0;
            limit_r <= RTDC_LIMIT_RST;
        end else if (ce_i) begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            trip_r <= trip_nxt;
            limit_r <= limit_sel;
            fault_r <= trip_nxt || (fault_r && !fault_clr_i);
        end
    end

    assign limit_active_o = limit_r;
    assign trip_o = trip_r;
    assign fault_o = fault_r;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_wr12;
        ce_i && cmd_wr_i && page_i == RTDC_PAGE_RAIL1 && cmd_code_i == RTDC_CMD_LIMIT_12;
    endsequence
    sequence s_rd12;
        ce_i && cmd_rd_i && page_i == RTDC_PAGE_RAIL1 && cmd_code_i == RTDC_CMD_LIMIT_12
            && !cmd_wr_i;
    endsequence

    a_rsv_read_zero: assert property (
        rdata_o[RTDC_RSV_MSB:RTDC_RSV_LSB] == RTDC_RSV_VAL)
        else $error("reserved bits read nonzero");

    a_two_phase_fld: assert property (
        s_wr12 ##1 1'b1 |-> fld_q[1] == $past(wdata_i[RTDC_HI_MSB:RTDC_HI_LSB]))
        else $error("two-phase field not stored");

    a_one_phase_fld: assert property (
        s_wr12 |=> fld_q[0] == $past(wdata_i[RTDC_LO_MSB:RTDC_LO_LSB]))
        else $error("one-phase field not stored");

    a_four_phase_fld: assert property (
        ce_i && cmd_wr_i && page_i == RTDC_PAGE_RAIL1 && cmd_code_i == RTDC_CMD_LIMIT_34
        |=> fld_q[3] == $past(wdata_i[RTDC_HI_MSB:RTDC_HI_LSB]))
        else $error("four-phase field not stored");

    a_three_rd_back: assert property (
        ce_i && cmd_rd_i && !cmd_wr_i && page_i == RTDC_PAGE_RAIL1
            && cmd_code_i == RTDC_CMD_LIMIT_34
        |=> rdata_o[RTDC_LO_MSB:RTDC_LO_LSB] == $past(fld_q[2])
            && rdata_o[RTDC_HI_MSB:RTDC_HI_LSB] == $past(fld_q[3]))
        else $error("three/four-phase readback wrong");

    a_rd_after_wr: assert property (
        s_wr12 ##1 s_rd12 |=> rdata_o == {RTDC_RSV_VAL, $past(wdata_i[RTDC_HI_MSB:0], 2)})
        else $error("readback differs from written value");

    a_page_guard: assert property (
        ce_i && (cmd_wr_i || cmd_rd_i) && page_i != RTDC_PAGE_RAIL1
        |=> cmd_nak_o && !cmd_ack_o)
        else $error("off-page command accepted");

    a_other_page_wr: assert property (
        ce_i && cmd_wr_i && page_i != RTDC_PAGE_RAIL1 |=> $stable(fld_q[0]) && $stable(fld_q[3]))
        else $error("off-page write changed a limit");

    // A trip held by a low enable is not a fresh trip
    a_trip_run: assert property (
        trip_o && $past(ce_i) |-> $past(state_r) == RTDC_ST_OVER
            && $past(cnt_r) == RTDC_TRIP_SAMPLES - RTDC_CNT_ONE)
        else $error("trip without full over-limit run");

    a_fault_set: assert property (
        ce_i && trip_nxt |=> fault_o)
        else $error("fault not raised on trip");

    a_limit_sel: assert property (
        ce_i |=> limit_active_o == $past(fld_q[phases_i]))
        else $error("active limit not matching phase count");
endmodule

// ===== logic/rtdc_pkg.sv
// Operation
// - Bits 15:12 of both limit registers ignore writes and read as zero.
// - Low-count register bits 11:6 hold the two-phase sustained limit.
// - Low-count register bits 5:0 hold the one-phase sustained limit.
// - High-count register bits 11:6 hold the four-phase sustained limit.
// - High-count register bits 5:0 hold the three-phase sustained limit.
// - One limit LSB equals 40 over current-sense gain, in amperes.
// - Limit registers answer command codes CEh and CFh on page 0 only.
package rtdc_pkg;
    // Command codes and page
    localparam logic [7:0] RTDC_CMD_LIMIT_12 = 8'hce;
    localparam logic [7:0] RTDC_CMD_LIMIT_34 = 8'hcf;
    localparam logic [7:0] RTDC_PAGE_RAIL1 = 8'h00;
    // Field layout
    localparam int RTDC_FLD_W = 6;
    localparam int RTDC_HI_LSB = 6;
    localparam int RTDC_HI_MSB = 11;
    localparam int RTDC_LO_LSB = 0;
    localparam int RTDC_LO_MSB = 5;
    localparam int RTDC_RSV_LSB = 12;
    localparam int RTDC_RSV_MSB = 15;
    localparam logic [3:0] RTDC_RSV_VAL = 4'h0;
    // Field reset value and scale numerator in A per LSB times gain
    localparam logic [5:0] RTDC_LIMIT_RST = 6'h3f;
    localparam int RTDC_LSB_NUM_A = 40;
    // Sense width and samples over limit needed to trip
    localparam int RTDC_SENSE_W = 7;
    localparam logic [2:0] RTDC_TRIP_SAMPLES = 3'h4;
    localparam logic [2:0] RTDC_CNT_ONE = 3'h1;
    // Phase count codes (active phases minus one)
    localparam logic [1:0] RTDC_PH_ONE = 2'h0;
    localparam logic [1:0] RTDC_PH_TWO = 2'h1;
    localparam logic [1:0] RTDC_PH_THREE = 2'h2;
    localparam logic [1:0] RTDC_PH_FOUR = 2'h3;
    // Detector states, Gray along clear, over, trip
    typedef enum logic [1:0] {
        RTDC_ST_CLEAR = 2'h0,
        RTDC_ST_OVER = 2'h1,
        RTDC_ST_TRIP = 2'h3
    } rtdc_state_e;
endpackage

// ===== logic/rtdc_field.sv
`timescale 1ns/100ps
module rtdc_field (
    // Clock, reset, enable
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // Write port
    input wire logic we_i,
    input wire logic [rtdc_pkg::RTDC_FLD_W-1:0] d_i,
    // Stored field
    output logic [rtdc_pkg::RTDC_FLD_W-1:0] q_o
);
    import rtdc_pkg::*;

    logic [RTDC_FLD_W-1:0] q_r;

    // Field storage, loads on write while enabled
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q_r <= RTDC_LIMIT_RST;
        end else if (ce_i && we_i) begin
            q_r <= d_i;
        end
    end

    assign q_o = q_r;
endmodule

// ===== dv/rtdc_host.sv
`timescale 1ns/100ps
// Management host stand-in that drives the command port
module rtdc_host (
    // Clock
    input wire logic mclk_i,
    // Command port toward the device
    output logic cmd_wr_o,
    output logic cmd_rd_o,
    output logic [7:0] cmd_code_o,
    output logic [7:0] page_o,
    output logic [15:0] wdata_o,
    input wire logic [15:0] rdata_i,
    input wire logic cmd_ack_i,
    input wire logic cmd_nak_i
);
    // Idle lines at time zero
    initial begin
        cmd_wr_o = 1'b0;
        cmd_rd_o = 1'b0;
        cmd_code_o = 8'h00;
        page_o = 8'h00;
        wdata_o = 16'h0000;
    end
    // One request held for one edge, answer taken one cycle later
    // code and page
    task automatic xfer(input logic wr, input logic [7:0] code, input logic [7:0] page,
            input logic [15:0] wd, output logic ack, output logic nak, output logic [15:0] rd);
        @(posedge mclk_i);
        #1;
        cmd_wr_o = wr;
        cmd_rd_o = ~wr;
        cmd_code_o = code;
        page_o = page;
        wdata_o = wd;
        @(posedge mclk_i);
        #1;
        cmd_wr_o = 1'b0;
        cmd_rd_o = 1'b0;
        // Released lines stop showing the last value
        cmd_code_o = ~code;
        page_o = ~page;
        wdata_o = ~wd;
        ack = cmd_ack_i;
        nak = cmd_nak_i;
        rd = rdata_i;
    endtask
endmodule

// ===== dv/rtdc_top_test.sv
`timescale 1ns/100ps
module rtdc_top_test;
    import rtdc_pkg::*;
    logic mclk_i, rst_n_i, ce_i, cmd_wr, cmd_rd, cmd_ack, cmd_nak, sense_vld, fault_clr;
    logic [7:0] cmd_code, page;
    logic [15:0] wdata, rdata;
    logic [1:0] phases;
    logic [RTDC_SENSE_W-1:0] sense;
    logic [RTDC_FLD_W-1:0] limit_active;
    logic trip, fault;
    logic ack_s, nak_s;
    logic [15:0] rd_s;
    int errors = 0;
    int tests_run = 0;
    logic [5:0] lim [4] = '{6'h3c, 6'h2a, 6'h23, 6'h04};
    logic [6:0] run [8] = '{7'h3d, 7'h3d, 7'h3d, 7'h3c, 7'h3d, 7'h3d, 7'h3d, 7'h3d};
    ////////////////////////////////////////////////////////////////////////
    rtdc_top rtdc_top_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
        .cmd_wr_i(cmd_wr), .cmd_rd_i(cmd_rd), .cmd_code_i(cmd_code), .page_i(page),
        .wdata_i(wdata), .rdata_o(rdata), .cmd_ack_o(cmd_ack), .cmd_nak_o(cmd_nak),
        .phases_i(phases), .sense_vld_i(sense_vld), .sense_i(sense), .fault_clr_i(fault_clr),
        .limit_active_o(limit_active), .trip_o(trip), .fault_o(fault));
    rtdc_host rtdc_host_inst (.mclk_i(mclk_i), .cmd_wr_o(cmd_wr), .cmd_rd_o(cmd_rd),
        .cmd_code_o(cmd_code), .page_o(page), .wdata_o(wdata), .rdata_i(rdata),
        .cmd_ack_i(cmd_ack), .cmd_nak_i(cmd_nak));
    ////////////////////////////////////////////////////////////////////////
    // Clock at 50 ns
    initial begin
        mclk_i = 1'b0;
        forever #25 mclk_i = ~mclk_i;
    end
    // Compare and count
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Command with expected answer; read data checked on reads only
    task automatic cmd(input logic wr, input logic [7:0] code, input logic [7:0] pg,
            input logic [15:0] wd, input logic ok, input logic [15:0] exp);
        logic ack, nak;
        logic [15:0] rd;
        rtdc_host_inst.xfer(wr, code, pg, wd, ack, nak, rd);
        chk("ack", {15'h0, ack}, {15'h0, ok});
        chk("nak", {15'h0, nak}, {15'h0, ~ok});
        if (!wr) begin
            chk("rdata", rd, exp);
        end
    endtask
    // One current sample, trip pulse seen one cycle after it is taken
    task automatic smp(input logic [6:0] v, input logic exp_trip);
        @(posedge mclk_i);
        #1;
        sense_vld = 1'b1;
        sense = v;
        @(posedge mclk_i);
        #1;
        sense_vld = 1'b0;
        sense = ~v;
        chk("trip", {15'h0, trip}, {15'h0, exp_trip});
    endtask
    task automatic give_verdict();
        $display("Checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Hang guard
    initial begin
        #2000000;
        errors++;
        give_verdict();
    end
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        rst_n_i = 1'b0;
        ce_i = 1'b1;
        phases = 2'h0;
        sense_vld = 1'b0;
        sense = 7'h00;
        fault_clr = 1'b0;
        repeat (2) @(posedge mclk_i);
        #1;
        rst_n_i = 1'b1;
        cmd(1'b0, RTDC_CMD_LIMIT_12, 8'h00, 16'h0, 1'b1, 16'h0fff);
        cmd(1'b0, RTDC_CMD_LIMIT_34, 8'h00, 16'h0, 1'b1, 16'h0fff);
        cmd(1'b1, RTDC_CMD_LIMIT_12, 8'h00, 16'hfabc, 1'b1, 16'h0);
        cmd(1'b0, RTDC_CMD_LIMIT_12, 8'h00, 16'h0, 1'b1, 16'h0abc);
        cmd(1'b1, RTDC_CMD_LIMIT_34, 8'h00, 16'h5123, 1'b1, 16'h0);
        cmd(1'b0, RTDC_CMD_LIMIT_34, 8'h00, 16'h0, 1'b1, 16'h0123);
        cmd(1'b1, RTDC_CMD_LIMIT_12, 8'h01, 16'h0fff, 1'b0, 16'h0);
        cmd(1'b0, 8'hd0, 8'h00, 16'h0, 1'b0, 16'h0000);
        cmd(1'b0, RTDC_CMD_LIMIT_12, 8'h01, 16'h0, 1'b0, 16'h0000);
        cmd(1'b0, RTDC_CMD_LIMIT_12, 8'h00, 16'h0, 1'b1, 16'h0abc);
        // Low enable freezes the port: no answer and no write
        @(posedge mclk_i);
        #1;
        ce_i = 1'b0;
        rtdc_host_inst.xfer(1'b1, RTDC_CMD_LIMIT_12, 8'h00, 16'h0555, ack_s, nak_s, rd_s);
        ce_i = 1'b1;
        chk("ack", {15'h0, ack_s}, 16'h0000);
        chk("nak", {15'h0, nak_s}, 16'h0000);
        cmd(1'b0, RTDC_CMD_LIMIT_12, 8'h00, 16'h0, 1'b1, 16'h0abc);
        $display("Test registers done");
        // Active limit follows the phase count
        for (int p = 0; p < 4; p++) begin
            phases = p[1:0];
            repeat (2) @(posedge mclk_i);
            #1;
            chk("limit_active", {10'h0, limit_active}, {10'h0, lim[p]});
        end
        $display("Test phase select done");
        // Raw code compare, equal is not over, under sample restarts the run
        phases = RTDC_PH_ONE;
        for (int i = 0; i < 8; i++) begin
            smp(run[i], i == 7);
        end
        chk("fault", {15'h0, fault}, 16'h0001);
        @(posedge mclk_i);
        #1;
        fault_clr = 1'b1;
        @(posedge mclk_i);
        #1;
        fault_clr = 1'b0;
        chk("fault", {15'h0, fault}, 16'h0000);
        // Trip and clear in one cycle, the trip wins
        @(posedge mclk_i);
        #1;
        fault_clr = 1'b1;
        smp(7'h3c, 1'b0);
        for (int i = 0; i < 4; i++) begin
            smp(7'h3d, i == 3);
        end
        chk("fault", {15'h0, fault}, 16'h0001);
        fault_clr = 1'b0;
        // Reset after the trip returns limits and the fault flag to start values
        @(posedge mclk_i);
        #1;
        rst_n_i = 1'b0;
        repeat (2) @(posedge mclk_i);
        #1;
        chk("fault", {15'h0, fault}, 16'h0000);
        chk("limit_active", {10'h0, limit_active}, {10'h0, RTDC_LIMIT_RST});
        rst_n_i = 1'b1;
        cmd(1'b0, RTDC_CMD_LIMIT_34, 8'h00, 16'h0, 1'b1, 16'h0fff);
        $display("Test detector done");
        give_verdict();
    end
endmodule
